// ===== hw/dcud_cfg.svh
// Constants of the channel update command decoder: codes, field positions,
// widths and reset values. Included by the package and the design modules.
//
// Overview of operation
// - Command 0001 with channel code 0 to 7 copies that channel's input register into its DAC register, data ignored.
// - Channel codes 0 to 7 select the eight channels in binary order.
// - Command 0001 with channel code 1111 copies all eight input registers into their DAC registers.
// - Any other channel code with its top bit set is invalid and changes nothing.
// - Command 0011 with channel code 0 to 7 loads that input register and updates only that channel's DAC register.
// - The 12-bit value is the upper data byte followed by the upper nibble of the lower data byte.
// - Command 0011 with code 1111 loads all eight input registers and updates all eight DAC registers.
// - Command 0010 loads the addressed input register and then updates every DAC register.
// - Command 0000 with channel code 0 to 7 loads only that input register, with code 1111 all eight, and leaves the DAC registers alone.
`ifndef DCUD_CFG_SVH
`define DCUD_CFG_SVH

`define DCUD_NUM_CH 8
`define DCUD_DATA_W 12
`define DCUD_RST_VAL 12'h000

`define DCUD_CMD_WRITE 4'h0
`define DCUD_CMD_SEL_UPD 4'h1
`define DCUD_CMD_WR_UPD_ALL 4'h2
`define DCUD_CMD_WR_UPD_ONE 4'h3

`define DCUD_CH_ALL 4'hf
`define DCUD_CH_TOP_BIT 3
`define DCUD_CH_IDX_HI 2
`define DCUD_BYTE_RST 8'h00

`define DCUD_CMD_HI 7
`define DCUD_CMD_LO 4
`define DCUD_CH_HI 3
`define DCUD_CH_LO 0
`define DCUD_NIB_HI 7
`define DCUD_NIB_LO 4

`define DCUD_ST_IDLE 2'b00
`define DCUD_ST_CMD 2'b01
`define DCUD_ST_MSB 2'b11
`define DCUD_ST_DONE 2'b10

`endif

// ===== hw/dcud_pkg.sv
// Types shared by the command decoder and its channel register module.
// Assumes dcud_cfg.svh is on the include path.
`include "dcud_cfg.svh"

package dcud_pkg;

   typedef logic [`DCUD_DATA_W-1:0] dcud_code_t;
   typedef logic [`DCUD_NUM_CH*`DCUD_DATA_W-1:0] dcud_bank_t;
   typedef logic [`DCUD_NUM_CH-1:0] dcud_chmask_t;

   // Gray order along idle, command byte, upper byte, finished.
   typedef enum logic [1:0] {
      DCUD_IDLE = `DCUD_ST_IDLE,
      DCUD_CMD = `DCUD_ST_CMD,
      DCUD_MSB = `DCUD_ST_MSB,
      DCUD_DONE = `DCUD_ST_DONE
   } dcud_state_t;

endpackage

// ===== hw/dcud_chan_if.sv
// Carrier between the decoder and one channel's register pair.
// Assumes the package has been compiled first.
`timescale 1ns/1ps
`default_nettype none

interface dcud_chan_if;
   import dcud_pkg::*;

   logic loadIn;
   logic update;
   dcud_code_t data;
   dcud_code_t inputVal;
   dcud_code_t dacVal;

   modport ctrl (output loadIn, output update, output data, input inputVal, input dacVal);
   modport chan (input loadIn, input update, input data, output inputVal, output dacVal);
endinterface

`default_nettype wire

// ===== hw/dcud_channel.sv
// One converter channel: its input register and its DAC register.
// Assumes the decoder raises loadIn and update for one clock per command.
`timescale 1ns/1ps
`default_nettype none
`include "dcud_cfg.svh"

module dcud_channel (
   input wire logic clk,
   input wire logic nrst,
   dcud_chan_if.chan ch
);
   import dcud_pkg::*;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ch.inputVal <= `DCUD_RST_VAL;
      end else if (ch.loadIn) begin
         ch.inputVal <= ch.data;
      end
   end

   // A load and an update in the same cycle pass the new value straight
   // through, so the channel never shows the stale input for one clock.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ch.dacVal <= `DCUD_RST_VAL;
      end else if (ch.update) begin
         ch.dacVal <= ch.loadIn ? ch.data : ch.inputVal;
      end
   end

endmodule // dcud_channel

`default_nettype wire

// ===== hw/dcud_decoder.sv
// Top of the channel update command decoder: takes the command byte and the
// two data bytes of a serial write and drives the eight channel registers.
// Assumes the bus framing logic delivers each acknowledged byte of a write
// as a one-clock strobe, marks the start of the write after the address byte
// and marks its end by a stop or repeated start.
`timescale 1ns/1ps
`default_nettype none
`include "dcud_cfg.svh"

module dcud_decoder (
   input wire logic clk,
   input wire logic nrst,
   input wire logic frameStart,
   input wire logic frameEnd,
   input wire logic byteValid,
   input wire logic [7:0] byteData,
   output logic cmdDone,
   output logic cmdRejected,
   output dcud_pkg::dcud_bank_t inputRegs,
   output dcud_pkg::dcud_bank_t dacRegs
);
   import dcud_pkg::*;

   // ****************************************************************
   // Byte sequencing
   // ****************************************************************
   dcud_state_t state_reg;
   dcud_state_t state_next;
   logic [7:0] cmdByte_reg;
   logic [7:0] upperByte_reg;
   logic execute;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DCUD_IDLE: begin
            if (byteValid) begin
               state_next = DCUD_CMD;
            end
         end
         DCUD_CMD: begin
            if (byteValid) begin
               state_next = DCUD_MSB;
            end
         end
         DCUD_MSB: begin
            if (byteValid) begin
               state_next = DCUD_DONE;
            end
         end
         default: begin
            state_next = DCUD_DONE;
         end
      endcase
      // A frame boundary drops whatever part of a command was collected.
      if (frameStart || frameEnd) begin
         state_next = DCUD_IDLE;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= DCUD_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmdByte_reg <= `DCUD_BYTE_RST;
      end else if (byteValid && state_reg == DCUD_IDLE) begin
         cmdByte_reg <= byteData;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         upperByte_reg <= `DCUD_BYTE_RST;
      end else if (byteValid && state_reg == DCUD_CMD) begin
         upperByte_reg <= byteData;
      end
   end

   // Acting only on the third acknowledged byte keeps a truncated write harmless.
   assign execute = byteValid && state_reg == DCUD_MSB && !frameStart && !frameEnd;

   // ****************************************************************
   // Command decode
   // ****************************************************************
   logic [3:0] cmdCode;
   logic [3:0] chCode;
   logic chBroadcast;
   logic chValid;
   logic knownCmd;
   dcud_code_t newValue;
   dcud_chmask_t chSel;
   dcud_chmask_t loadMask;
   dcud_chmask_t updMask;

   assign cmdCode = cmdByte_reg[`DCUD_CMD_HI:`DCUD_CMD_LO];
   assign chCode = cmdByte_reg[`DCUD_CH_HI:`DCUD_CH_LO];
   assign chBroadcast = chCode == `DCUD_CH_ALL;
   assign chValid = !chCode[`DCUD_CH_TOP_BIT] || chBroadcast;
   assign newValue = {upperByte_reg, byteData[`DCUD_NIB_HI:`DCUD_NIB_LO]};
   assign knownCmd = cmdCode == `DCUD_CMD_WRITE || cmdCode == `DCUD_CMD_SEL_UPD
      || cmdCode == `DCUD_CMD_WR_UPD_ALL || cmdCode == `DCUD_CMD_WR_UPD_ONE;

   always_comb begin
      chSel = '0;
      if (chBroadcast) begin
         chSel = '1;
      end else if (!chCode[`DCUD_CH_TOP_BIT]) begin
         chSel[chCode[`DCUD_CH_IDX_HI:`DCUD_CH_LO]] = 1'b1;
      end
   end

   always_comb begin
      loadMask = '0;
      updMask = '0;
      if (execute && chValid) begin
         case (cmdCode)
            `DCUD_CMD_WRITE: begin
               loadMask = chSel;
            end
            `DCUD_CMD_SEL_UPD: begin
               updMask = chSel;
            end
            `DCUD_CMD_WR_UPD_ALL: begin
               loadMask = chSel;
               updMask = '1;
            end
            `DCUD_CMD_WR_UPD_ONE: begin
               loadMask = chSel;
               updMask = chSel;
            end
            default: begin
               loadMask = '0;
               updMask = '0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Channel registers
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `DCUD_NUM_CH; gi++) begin : g_ch
         dcud_chan_if chIf ();
         assign chIf.loadIn = loadMask[gi];
         assign chIf.update = updMask[gi];
         assign chIf.data = newValue;
         assign inputRegs[gi*`DCUD_DATA_W +: `DCUD_DATA_W] = chIf.inputVal;
         assign dacRegs[gi*`DCUD_DATA_W +: `DCUD_DATA_W] = chIf.dacVal;
         dcud_channel u_channel (
            .clk(clk),
            .nrst(nrst),
            .ch(chIf.chan)
         );
      end
   endgenerate

   // ****************************************************************
   // Status strobes
   // ****************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmdDone <= 1'b0;
      end else begin
         cmdDone <= execute && chValid && knownCmd;
      end
   end

   // Invalid channel codes and commands outside this decoder are reported, not acted on.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmdRejected <= 1'b0;
      end else begin
         cmdRejected <= execute && !(chValid && knownCmd);
      end
   end

endmodule // dcud_decoder

`default_nettype wire

// ===== verification/dcud_decoder_props.sv
// Checker for the decoder top, bound after endmodule.
// Assumes answers land one clock after the third byte.
`timescale 1ns/1ps
`default_nettype none
module dcud_decoder_props (
   input wire logic clk,
   input wire logic nrst,
   input wire logic frameStart,
   input wire logic frameEnd,
   input wire logic byteValid,
   input wire logic [7:0] byteData,
   input wire logic cmdDone,
   input wire logic cmdRejected,
   input wire dcud_pkg::dcud_bank_t inputRegs,
   input wire dcud_pkg::dcud_bank_t dacRegs
);
   import dcud_pkg::*;
   logic [1:0] cntReg;
   logic [7:0] cmdReg, hiReg;
   logic [11:0] valReg;
   logic lastReg;
   wire logic take = byteValid && !frameStart && !frameEnd;
   wire logic [3:0] cmd = cmdReg[7:4];
   wire logic [3:0] ch = cmdReg[3:0];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cntReg <= 2'h0;
         cmdReg <= 8'h00;
         hiReg <= 8'h00;
         valReg <= 12'h000;
         lastReg <= 1'b0;
      end else begin
         lastReg <= take && cntReg == 2'h2;
         if (frameStart || frameEnd) cntReg <= 2'h0;
         else if (take && cntReg != 2'h3) cntReg <= cntReg + 2'h1;
         if (take && cntReg == 2'h0) cmdReg <= byteData;
         if (take && cntReg == 2'h1) hiReg <= byteData;
         if (take && cntReg == 2'h2) valReg <= {hiReg, byteData[7:4]};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_answer_cause: assert property ((cmdDone || cmdRejected) |-> lastReg)
      else $error("stray status");
   chk_third_answered: assert property (lastReg |-> cmdDone ^ cmdRejected)
      else $error("no answer");
   chk_quiet_hold: assert property (!cmdDone |-> $stable(inputRegs) && $stable(dacRegs))
      else $error("stray change");
   chk_write_only: assert property (cmdDone && cmd == 4'h0 |-> $stable(dacRegs))
      else $error("dac moved");
   chk_select_copy: assert property (cmdDone && cmd == 4'h1 |-> $stable(inputRegs))
      else $error("input moved");
   chk_all_follow: assert property (cmdDone && (cmd == 4'h2 || (ch == 4'hf && cmd != 4'h0))
      |-> dacRegs == inputRegs)
      else $error("bank differs");
   chk_one_update: assert property (cmdDone && cmd == 4'h3 && !ch[3]
      |-> dacRegs[ch[2:0]*12 +: 12] == valReg)
      else $error("wrong channel");
   chk_bcast_load: assert property (cmdDone && ch == 4'hf && cmd != 4'h1 |-> inputRegs == {8{valReg}})
      else $error("broadcast load");
   cover property (cmdDone && cmd == 4'h3);
   cover property (cmdRejected);
   cover property (cmdDone && ch == 4'hf);
endmodule // dcud_decoder_props
bind dcud_decoder dcud_decoder_props u_props (.clk(clk), .nrst(nrst), .frameStart(frameStart),
   .frameEnd(frameEnd), .byteValid(byteValid), .byteData(byteData), .cmdDone(cmdDone),
   .cmdRejected(cmdRejected), .inputRegs(inputRegs), .dacRegs(dacRegs));
`default_nettype wire

// ===== verification/dcud_host_model.sv
// Bus master side: frames a write and hands over acknowledged bytes.
// Assumes a free running clk; drives 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module dcud_host_model (
   input wire logic clk,
   output logic frameStart,
   output logic frameEnd,
   output logic byteValid,
   output logic [7:0] byteData
);
   initial begin
      frameStart = 1'b0;
      frameEnd = 1'b0;
      byteValid = 1'b0;
      byteData = 8'h00;
   end
   task automatic write(input logic [23:0] bytes, input int n);
      @(posedge clk);
      #1 frameStart = 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #1 frameStart = 1'b0;
         byteValid = 1'b1;
         byteData = bytes[23-8*i -: 8];
      end
      @(posedge clk);
      #1 byteValid = 1'b0;
      // Stale data would hide a decoder that ignores the strobe.
      byteData = ~byteData;
   endtask
   task automatic stop();
      frameEnd = 1'b1;
      @(posedge clk);
      #1 frameEnd = 1'b0;
   endtask
endmodule // dcud_host_model
`default_nettype wire

// ===== verification/test_dcud_decoder.sv
// Self-checking bench of the decoder against an integer model.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module test_dcud_decoder;
   import dcud_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic frameStart, frameEnd, byteValid, cmdDone, cmdRejected;
   logic [7:0] byteData;
   dcud_bank_t inputRegs, dacRegs, expIn, expDac;
   int checks = 0;
   int fails = 0;
   int unsigned seed = 30;
   int inp[8];
   int dac[8];
   always #2 clk = ~clk;
   dcud_host_model u_host (.clk(clk), .frameStart(frameStart), .frameEnd(frameEnd),
      .byteValid(byteValid), .byteData(byteData));
   dcud_decoder u_dcud_decoder (.clk(clk), .nrst(nrst), .frameStart(frameStart),
      .frameEnd(frameEnd), .byteValid(byteValid), .byteData(byteData), .cmdDone(cmdDone),
      .cmdRejected(cmdRejected), .inputRegs(inputRegs), .dacRegs(dacRegs));
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end
   initial begin
      int cmd, ch, val, n;
      logic ok;
      inp = '{default: 0};
      dac = '{default: 0};
      repeat (12) @(posedge clk);
      #1 nrst = 1'b1;
      for (int i = 0; i < 80; i++) begin
         if (i == 40) begin
            nrst = 1'b0;
            inp = '{default: 0};
            dac = '{default: 0};
            @(posedge clk);
            #1 nrst = 1'b1;
         end
         cmd = i % 5;
         ch = (i % 3 == 0) ? 15 : xs() % 16;
         val = xs() % 4096;
         n = (i % 7 == 6) ? 2 : 3;
         u_host.write({4'(cmd), 4'(ch), 12'(val), 4'(xs())}, n);
         ok = n == 3 && cmd < 4 && (ch < 8 || ch == 15);
         for (int c = 0; c < 8; c++) begin
            if (ok && (ch == c || ch == 15)) begin
               if (cmd != 1) inp[c] = val;
               if (cmd == 1 || cmd == 3) dac[c] = inp[c];
            end
         end
         for (int c = 0; c < 8; c++) begin
            if (ok && cmd == 2) dac[c] = inp[c];
            expIn[c*12 +: 12] = 12'(inp[c]);
            expDac[c*12 +: 12] = 12'(dac[c]);
         end
         `CHK(cmdDone, ok)
         `CHK(cmdRejected, n == 3 && !ok)
         `CHK(inputRegs, expIn)
         `CHK(dacRegs, expDac)
         u_host.stop();
      end
      summarize();
   end
endmodule // test_dcud_decoder
`default_nettype wire
